// *** verilog/skip_exec_map.vh ***
// Opcodes, register offsets, field positions and reset values for the skip/subtract/swap unit
`ifndef SKIP_EXEC_MAP_VH
`define SKIP_EXEC_MAP_VH

// ----------------------------------------------------------------------------
// Operation codes from the decoder
// ----------------------------------------------------------------------------
`define OP_W                    4
`define OP_INC_SKIP_ZERO_TO_ACC 4'h0
`define OP_SKIP_IF_NONZERO_BIT  4'h1
`define OP_SKIP_IF_NONZERO      4'h2
`define OP_SUBTRACT_TO_ACC      4'h3
`define OP_SUBTRACT_TO_MEM      4'h4
`define OP_NIBBLE_SWAP_MEM      4'h5
`define OP_NIBBLE_SWAP_TO_ACC   4'h6
`define OP_SKIP_IF_ZERO         4'h7
`define OP_COPY_SKIP_IF_ZERO    4'h8

// ----------------------------------------------------------------------------
// Data path constants
// ----------------------------------------------------------------------------
`define BYTE_ZERO               8'h00
`define BYTE_ONE                8'h01

// ----------------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------------
`define ADDR_W                  12
`define REG_ACC                 12'h000
`define REG_FLAGS               12'h004
`define REG_CTRL                12'h008
`define REG_STAT                12'h00c

// ----------------------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------------------
`define FLAG_W                  6
`define FLG_C                   0
`define FLG_AC                  1
`define FLG_Z                   2
`define FLG_OV                  3
`define FLG_SC                  4
`define FLG_CZ                  5

// ----------------------------------------------------------------------------
// Control / status fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_EN                 0
`define STAT_BUSY               0
`define STAT_LAST_SKIP          1
`define STAT_BAD_OP             2
`define STAT_CNT_LSB            8
`define STAT_CNT_MSB            15
`define RST_ACC                 8'h00
`define RST_FLAGS               6'h00
`define RST_EN                  1'b1
`define RST_CNT                 8'h00

`endif

// *** verilog/sub8_flags.v ***
// Eight-bit subtractor producing the difference and the six status flags
`timescale 1ns/1ps
`include "skip_exec_map.vh"
module sub8_flags (
  a,
  b,
  diff,
  flags
);
  input  wire [7:0]            a;
  input  wire [7:0]            b;
  output wire [7:0]            diff;
  output wire [`FLAG_W-1:0]    flags;

  wire [8:0] full;
  wire [4:0] low;
  wire       ov;
  wire       z;

  // Carry out of a two's complement subtract is the inverse of borrow
  assign full = {1'b0, a} + {1'b0, ~b} + 9'h001;
  assign low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
  assign diff = full[7:0];
  assign z    = (full[7:0] == `BYTE_ZERO);
  assign ov   = (a[7] != b[7]) && (full[7] != a[7]);

  assign flags[`FLG_C]  = full[8];
  assign flags[`FLG_AC] = low[4];
  assign flags[`FLG_Z]  = z;
  assign flags[`FLG_OV] = ov;
  // Signed compare: set when the signed difference is not negative
  assign flags[`FLG_SC] = ~(ov ^ full[7]);
  assign flags[`FLG_CZ] = z;
endmodule // sub8_flags

// *** verilog/skip_eval.v ***
// Skip condition evaluation for the conditional-skip operations
`timescale 1ns/1ps
`include "skip_exec_map.vh"
module skip_eval (
  op,
  mem_byte,
  bit_sel,
  inc_byte,
  is_skip_op,
  skip_cond
);
  input  wire [`OP_W-1:0] op;
  input  wire [7:0]       mem_byte;
  input  wire [2:0]       bit_sel;
  output wire [7:0]       inc_byte;
  output reg              is_skip_op;
  output reg              skip_cond;

  assign inc_byte = mem_byte + `BYTE_ONE;

  always @* begin
    is_skip_op = 1'b1;
    skip_cond  = 1'b0;
    case (op)
      `OP_INC_SKIP_ZERO_TO_ACC: skip_cond = (inc_byte == `BYTE_ZERO);
      `OP_SKIP_IF_NONZERO_BIT:  skip_cond = mem_byte[bit_sel];
      `OP_SKIP_IF_NONZERO:      skip_cond = (mem_byte != `BYTE_ZERO);
      `OP_SKIP_IF_ZERO:         skip_cond = (mem_byte == `BYTE_ZERO);
      `OP_COPY_SKIP_IF_ZERO:    skip_cond = (mem_byte == `BYTE_ZERO);
      default:                  is_skip_op = 1'b0;
    endcase
  end
endmodule // skip_eval

// *** verilog/skip_subtract_swap_exec.v ***
// Execution unit for the skip, subtract and nibble-swap instruction group
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "skip_exec_map.vh"

// Functional notes
// - Increment-skip puts memory byte plus one in accumulator; skip when zero.
// - Every conditional skip occupies two cycles, whether it skips or not.
// - Bit-test skip-if-nonzero skips when the selected memory bit is one.
// - Byte skip-if-nonzero skips on any non-zero byte; flags untouched.
// - Subtract-to-acc writes acc minus memory to acc and updates six flags.
// - Carry clears on borrow, sets when the difference is zero or positive.
// - Subtract-to-memory writes acc minus memory back to memory, same flags.
// - Swap-in-memory exchanges memory nibbles in place; flags unchanged.
// - Swap-to-acc puts swapped memory nibbles in acc; memory and flags kept.
// - Byte skip-if-zero skips when the byte is zero; nothing altered.
// - Copy-skip loads memory byte into acc; skips when zero; flags kept.
module skip_subtract_swap_exec (
  clk_sys,
  resetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  exec_valid,
  exec_op,
  exec_bit,
  mem_rdata,
  exec_ready,
  mem_we,
  mem_wdata,
  acc,
  status_flags,
  pc_skip,
  nop_slot
);
  input  wire                clk_sys;
  input  wire                resetn;
  input  wire                psel;
  input  wire                penable;
  input  wire                pwrite;
  input  wire [`ADDR_W-1:0]  paddr;
  input  wire [31:0]         pwdata;
  output wire [31:0]         prdata;
  output wire                pready;
  output wire                pslverr;
  input  wire                exec_valid;
  input  wire [`OP_W-1:0]    exec_op;
  input  wire [2:0]          exec_bit;
  input  wire [7:0]          mem_rdata;
  output wire                exec_ready;
  output wire                mem_we;
  output wire [7:0]          mem_wdata;
  output wire [7:0]          acc;
  output wire [`FLAG_W-1:0]  status_flags;
  output wire                pc_skip;
  output wire                nop_slot;

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_DUMMY = 2'b10;

  reg [1:0]          state_ff;
  reg [1:0]          nxt_state;
  reg [7:0]          acc_ff;
  reg [7:0]          nxt_acc;
  reg [`FLAG_W-1:0]  flags_ff;
  reg [`FLAG_W-1:0]  nxt_flags;
  reg                mem_we_ff;
  reg                nxt_mem_we;
  reg [7:0]          mem_wdata_ff;
  reg [7:0]          nxt_mem_wdata;
  reg                ready_ff;
  reg                nxt_ready;
  reg                pc_skip_ff;
  reg                nxt_pc_skip;
  reg                nop_slot_ff;
  reg                nxt_nop_slot;
  reg                en_ff;
  reg                nxt_en;
  reg                last_skip_ff;
  reg                nxt_last_skip;
  reg                bad_op_ff;
  reg                nxt_bad_op;
  reg [7:0]          skip_cnt_ff;
  reg [7:0]          nxt_skip_cnt;
  reg [31:0]         prdata_ff;
  reg [31:0]         nxt_prdata;
  reg                pready_ff;
  reg                nxt_pready;
  reg                pslverr_ff;
  reg                nxt_pslverr;

  wire [7:0]         sub_diff;
  wire [`FLAG_W-1:0] sub_flags;
  wire [7:0]         inc_byte;
  wire               is_skip_op;
  wire               skip_cond;
  wire [7:0]         swapped;
  wire               take;
  wire               apb_setup;
  wire               apb_wr;
  reg                addr_hit;
  reg [31:0]         rd_mux;

  sub8_flags u_sub (
    .a     (acc_ff),
    .b     (mem_rdata),
    .diff  (sub_diff),
    .flags (sub_flags)
  );

  skip_eval u_skip (
    .op         (exec_op),
    .mem_byte   (mem_rdata),
    .bit_sel    (exec_bit),
    .inc_byte   (inc_byte),
    .is_skip_op (is_skip_op),
    .skip_cond  (skip_cond)
  );

  // Nibble exchange is pure wiring shared by both swap forms
  assign swapped = {mem_rdata[3:0], mem_rdata[7:4]};
  assign take    = exec_valid && ready_ff && (state_ff == ST_IDLE);

  // --------------------------------------------------------------------------
  // APB slave: one wait-free access phase, pready asserted in it
  // --------------------------------------------------------------------------
  assign apb_setup = psel && !penable;
  // Writes land only in the answered access cycle; unmapped offsets are dropped
  assign apb_wr    = psel && penable && pready_ff && pwrite && !pslverr_ff;

  always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h00000000;
    case (paddr)
      `REG_ACC:   rd_mux[7:0] = acc_ff;
      `REG_FLAGS: rd_mux[`FLAG_W-1:0] = flags_ff;
      `REG_CTRL:  rd_mux[`CTRL_EN] = en_ff;
      `REG_STAT: begin
        rd_mux[`STAT_BUSY]                    = (state_ff != ST_IDLE);
        rd_mux[`STAT_LAST_SKIP]               = last_skip_ff;
        rd_mux[`STAT_BAD_OP]                  = bad_op_ff;
        rd_mux[`STAT_CNT_MSB:`STAT_CNT_LSB]   = skip_cnt_ff;
      end
      default:    addr_hit = 1'b0;
    endcase
  end

  always @* begin
    nxt_pready  = apb_setup;
    nxt_pslverr = apb_setup ? !addr_hit : 1'b0;
    nxt_prdata  = (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
  end

  // --------------------------------------------------------------------------
  // Execution sequencer
  // --------------------------------------------------------------------------
  always @* begin
    nxt_state     = state_ff;
    nxt_acc       = acc_ff;
    nxt_flags     = flags_ff;
    nxt_mem_we    = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_ready     = en_ff;
    nxt_pc_skip   = 1'b0;
    nxt_nop_slot  = 1'b0;
    nxt_en        = en_ff;
    nxt_last_skip = last_skip_ff;
    nxt_bad_op    = bad_op_ff;
    nxt_skip_cnt  = skip_cnt_ff;

    // Software writes land first so that a same-cycle instruction result wins
    if (apb_wr) begin
      case (paddr)
        `REG_ACC:   nxt_acc = pwdata[7:0];
        `REG_FLAGS: nxt_flags = pwdata[`FLAG_W-1:0];
        `REG_CTRL:  nxt_en = pwdata[`CTRL_EN];
        `REG_STAT: begin
          // Write one to clear; a same-cycle bad opcode still sets it
          if (pwdata[`STAT_BAD_OP]) nxt_bad_op = 1'b0;
          if (pwdata[`STAT_CNT_MSB:`STAT_CNT_LSB] != `RST_CNT) nxt_skip_cnt = `RST_CNT;
        end
        default: nxt_en = en_ff;
      endcase
      nxt_ready = (paddr == `REG_CTRL) ? pwdata[`CTRL_EN] : en_ff;
    end

    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          case (exec_op)
            `OP_INC_SKIP_ZERO_TO_ACC: nxt_acc = inc_byte;
            `OP_COPY_SKIP_IF_ZERO:    nxt_acc = mem_rdata;
            `OP_SUBTRACT_TO_ACC: begin
              nxt_acc   = sub_diff;
              nxt_flags = sub_flags;
            end
            `OP_SUBTRACT_TO_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = sub_diff;
              nxt_flags     = sub_flags;
            end
            `OP_NIBBLE_SWAP_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = swapped;
            end
            `OP_NIBBLE_SWAP_TO_ACC:   nxt_acc = swapped;
            `OP_SKIP_IF_NONZERO_BIT,
            `OP_SKIP_IF_NONZERO,
            `OP_SKIP_IF_ZERO: begin
              // Pure tests write nothing, so a same-cycle bus write still lands
              nxt_mem_we = 1'b0;
            end
            // Unknown codes change nothing but leave a sticky mark for software
            default:                  nxt_bad_op = 1'b1;
          endcase
          if (is_skip_op) begin
            // Two-cycle form: second cycle is the inserted dummy slot
            nxt_state     = ST_DUMMY;
            nxt_ready     = 1'b0;
            nxt_nop_slot  = 1'b1;
            nxt_pc_skip   = skip_cond;
            nxt_last_skip = skip_cond;
            // Wraps at its width; software clears it with a non-zero write
            if (skip_cond) nxt_skip_cnt = skip_cnt_ff + `BYTE_ONE;
          end
        end
      end
      ST_DUMMY: begin
        nxt_state = ST_IDLE;
        // Follow a same-cycle enable write, else a disable leaks one ready cycle
        nxt_ready = nxt_en;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_ready = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Synchronous reset only: every flop but en_ff and state_ff clears on the clock edge; en_ff sets, state_ff loads ST_IDLE
  always @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff     <= ST_IDLE;
      acc_ff       <= `RST_ACC;
      flags_ff     <= `RST_FLAGS;
      mem_we_ff    <= 1'b0;
      mem_wdata_ff <= `BYTE_ZERO;
      ready_ff     <= 1'b0;
      pc_skip_ff   <= 1'b0;
      nop_slot_ff  <= 1'b0;
      en_ff        <= `RST_EN;
      last_skip_ff <= 1'b0;
      bad_op_ff    <= 1'b0;
      skip_cnt_ff  <= `RST_CNT;
      prdata_ff    <= 32'h00000000;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      acc_ff       <= nxt_acc;
      flags_ff     <= nxt_flags;
      mem_we_ff    <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
      ready_ff     <= nxt_ready;
      pc_skip_ff   <= nxt_pc_skip;
      nop_slot_ff  <= nxt_nop_slot;
      en_ff        <= nxt_en;
      last_skip_ff <= nxt_last_skip;
      bad_op_ff    <= nxt_bad_op;
      skip_cnt_ff  <= nxt_skip_cnt;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs: every port is driven straight from a flop
  // --------------------------------------------------------------------------
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign exec_ready   = ready_ff;
  assign mem_we       = mem_we_ff;
  assign mem_wdata    = mem_wdata_ff;
  assign acc          = acc_ff;
  assign status_flags = flags_ff;
  assign pc_skip      = pc_skip_ff;
  assign nop_slot     = nop_slot_ff;
endmodule // skip_subtract_swap_exec

// *** bench/skip_exec_properties.sv ***
// Checker of per-opcode results and the skip dummy cycle
`timescale 1ns/1ps
`include "skip_exec_map.vh"
module skip_exec_properties (
  input wire               clk_sys,
  input wire               resetn,
  input wire               exec_valid,
  input wire [`OP_W-1:0]   exec_op,
  input wire [2:0]         exec_bit,
  input wire [7:0]         mem_rdata,
  input wire               exec_ready,
  input wire               mem_we,
  input wire [7:0]         mem_wdata,
  input wire [7:0]         acc,
  input wire [`FLAG_W-1:0] status_flags,
  input wire               pc_skip,
  input wire               nop_slot
);
  reg                tk_ff;
  reg [`OP_W-1:0]    op_ff;
  reg [7:0]          m_ff;
  reg [7:0]          a_ff;
  reg [2:0]          b_ff;
  reg [`FLAG_W-1:0]  f_ff;
  wire [7:0]         dif = a_ff - m_ff;
  wire [7:0]         swp = {m_ff[3:0], m_ff[7:4]};
  // --------
  // Snapshot of the accepted instruction, judged one cycle on
  // --------
  always @(posedge clk_sys) begin
    tk_ff <= resetn & exec_valid & exec_ready;
    op_ff <= exec_op;
    m_ff  <= mem_rdata;
    a_ff  <= acc;
    b_ff  <= exec_bit;
    f_ff  <= status_flags;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence skip_take;
    exec_valid && exec_ready && exec_op inside {`OP_INC_SKIP_ZERO_TO_ACC, `OP_SKIP_IF_NONZERO_BIT,
      `OP_SKIP_IF_NONZERO, `OP_SKIP_IF_ZERO, `OP_COPY_SKIP_IF_ZERO};
  endsequence
  sequence dummy_cycle;
    nop_slot && !exec_ready ##1 !nop_slot;
  endsequence
  dummy_slot_a: assert property (skip_take |=> dummy_cycle)
    else $error("skip dummy cycle missing");
  inc_skip_a: assert property (tk_ff && op_ff == `OP_INC_SKIP_ZERO_TO_ACC |->
    acc == m_ff + 8'h01 && pc_skip == (m_ff == 8'hff)) else $error("inc skip wrong");
  bit_skip_a: assert property (tk_ff && op_ff == `OP_SKIP_IF_NONZERO_BIT |->
    pc_skip == m_ff[b_ff] && status_flags == f_ff) else $error("bit skip wrong");
  nz_skip_a: assert property (tk_ff && op_ff == `OP_SKIP_IF_NONZERO |->
    pc_skip == (m_ff != 8'h00) && status_flags == f_ff) else $error("nonzero skip wrong");
  sub_acc_a: assert property (tk_ff && op_ff == `OP_SUBTRACT_TO_ACC |->
    acc == dif && status_flags[`FLG_C] == (a_ff >= m_ff)) else $error("sub to acc wrong");
  sub_mem_a: assert property (tk_ff && op_ff == `OP_SUBTRACT_TO_MEM |->
    mem_we && mem_wdata == dif && status_flags[`FLG_C] == (a_ff >= m_ff)) else $error("sub to mem wrong");
  swap_mem_a: assert property (tk_ff && op_ff == `OP_NIBBLE_SWAP_MEM |->
    mem_we && mem_wdata == swp && status_flags == f_ff) else $error("mem swap wrong");
  swap_acc_a: assert property (tk_ff && op_ff == `OP_NIBBLE_SWAP_TO_ACC |->
    acc == swp && !mem_we && status_flags == f_ff) else $error("acc swap wrong");
  zero_skip_a: assert property (tk_ff && op_ff == `OP_SKIP_IF_ZERO |->
    pc_skip == (m_ff == 8'h00) && !mem_we && status_flags == f_ff) else $error("zero skip wrong");
  copy_skip_a: assert property (tk_ff && op_ff == `OP_COPY_SKIP_IF_ZERO |->
    acc == m_ff && pc_skip == (m_ff == 8'h00) && status_flags == f_ff) else $error("copy skip wrong");
endmodule // skip_exec_properties
bind skip_subtract_swap_exec skip_exec_properties u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .exec_valid(exec_valid), .exec_op(exec_op), .exec_bit(exec_bit), .mem_rdata(mem_rdata),
  .exec_ready(exec_ready), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
  .status_flags(status_flags), .pc_skip(pc_skip), .nop_slot(nop_slot));

// *** bench/tb_skip_subtract_swap_exec.sv ***
// Self-checking bench for the skip, subtract and swap unit
`timescale 1ns/1ps
`include "skip_exec_map.vh"
module tb_skip_subtract_swap_exec;
  reg                clk_sys = 1'b0;
  reg                resetn = 1'b0;
  reg                psel = 1'b0;
  reg                penable = 1'b0;
  reg                pwrite = 1'b0;
  reg [`ADDR_W-1:0]  paddr = 12'h000;
  reg [31:0]         pwdata = 32'h0;
  reg                exec_valid = 1'b0;
  reg [`OP_W-1:0]    exec_op = 4'h0;
  reg [2:0]          exec_bit = 3'h0;
  reg [7:0]          mem_rdata = 8'h00;
  wire [31:0]        prdata;
  wire               pready, pslverr, exec_ready, mem_we, pc_skip, nop_slot;
  wire [7:0]         mem_wdata, acc;
  wire [`FLAG_W-1:0] status_flags;
  integer            failures = 0;
  integer            check_count = 0;
  integer            n;
  reg [7:0]          ea = 8'h00;
  reg [7:0]          wd, cnt = 8'h00;
  reg [`FLAG_W-1:0]  ef = 6'h00;
  reg                sk, w, isk, ov, last = 1'b0;
  always #2 clk_sys = ~clk_sys;
  skip_subtract_swap_exec uut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_bit(exec_bit), .mem_rdata(mem_rdata),
    .exec_ready(exec_ready), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
    .status_flags(status_flags), .pc_skip(pc_skip), .nop_slot(nop_slot));
  // --------
  // Checking and bus tasks
  // --------
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wait_for(input ref_sig);
    begin
      if (n >= 20) begin
        failures = failures + 1;
        $display("BAD %0t no answer", $time);
        test_done;
      end
    end
  endtask
  task apb(input wr, input [`ADDR_W-1:0] a, input [31:0] d, input [31:0] ed, input ee);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      wait_for(pready);
      if (!wr) chk(prdata, ed);
      chk({31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // Expected results follow the documented arithmetic; flags kept in {CZ,SC,OV,Z,AC,C} order
  task run(input [3:0] op, input [7:0] m, input [2:0] b);
    begin
      sk = 1'b0;
      w = 1'b0;
      wd = 8'h00;
      isk = op <= `OP_SKIP_IF_NONZERO || op == `OP_SKIP_IF_ZERO || op == `OP_COPY_SKIP_IF_ZERO;
      case (op)
        `OP_INC_SKIP_ZERO_TO_ACC: begin
          ea = m + 8'h01;
          sk = ea == 8'h00;
        end
        `OP_SKIP_IF_NONZERO_BIT: sk = m[b];
        `OP_SKIP_IF_NONZERO: sk = m != 8'h00;
        `OP_SUBTRACT_TO_ACC, `OP_SUBTRACT_TO_MEM: begin
          wd = ea - m;
          ov = (ea[7] ^ m[7]) & (wd[7] ^ ea[7]);
          ef = {wd == 8'h00, ~(ov ^ wd[7]), ov, wd == 8'h00, ea[3:0] >= m[3:0], ea >= m};
          w = op == `OP_SUBTRACT_TO_MEM;
          if (!w) ea = wd;
        end
        `OP_NIBBLE_SWAP_MEM: begin
          w = 1'b1;
          wd = {m[3:0], m[7:4]};
        end
        `OP_NIBBLE_SWAP_TO_ACC: ea = {m[3:0], m[7:4]};
        `OP_SKIP_IF_ZERO: sk = m == 8'h00;
        `OP_COPY_SKIP_IF_ZERO: begin
          ea = m;
          sk = m == 8'h00;
        end
        default: isk = 1'b0;
      endcase
      exec_valid <= 1'b1;
      exec_op <= op;
      mem_rdata <= m;
      exec_bit <= b;
      n = 0;
      @(posedge clk_sys);
      while (exec_ready !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      wait_for(exec_ready);
      exec_valid <= 1'b0;
      @(posedge clk_sys);
      chk(acc, ea);
      chk(status_flags, ef);
      chk(pc_skip, sk);
      chk(nop_slot, isk);
      chk(mem_we, w);
      if (w) chk(mem_wdata, wd);
      if (isk) last = sk;
      cnt = cnt + {7'h0, sk};
    end
  endtask
  task sub(input [3:0] op, input [7:0] a, input [7:0] m);
    begin
      apb(1'b1, `REG_ACC, {24'h0, a}, 32'h0, 1'b0);
      ea = a;
      run(op, m, 3'h0);
    end
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk(acc, 8'h00);
    chk(status_flags, 6'h00);
    apb(1'b0, `REG_CTRL, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h010, 32'h5a, 32'h0, 1'b1);
    apb(1'b1, `REG_FLAGS, 32'h3f, 32'h0, 1'b0);
    ef = 6'h3f;
    apb(1'b0, `REG_FLAGS, 32'h0, 32'h3f, 1'b0);
    run(`OP_INC_SKIP_ZERO_TO_ACC, 8'hff, 3'h0);
    run(`OP_INC_SKIP_ZERO_TO_ACC, 8'h7f, 3'h0);
    run(`OP_SKIP_IF_NONZERO_BIT, 8'h20, 3'h5);
    run(`OP_SKIP_IF_NONZERO_BIT, 8'h20, 3'h4);
    run(`OP_SKIP_IF_NONZERO, 8'h00, 3'h0);
    run(`OP_SKIP_IF_NONZERO, 8'h01, 3'h0);
    run(`OP_SKIP_IF_ZERO, 8'h00, 3'h0);
    run(`OP_SKIP_IF_ZERO, 8'h80, 3'h0);
    run(`OP_COPY_SKIP_IF_ZERO, 8'h00, 3'h0);
    run(`OP_COPY_SKIP_IF_ZERO, 8'h5a, 3'h0);
    run(`OP_NIBBLE_SWAP_MEM, 8'ha5, 3'h0);
    run(`OP_NIBBLE_SWAP_TO_ACC, 8'h3c, 3'h0);
    sub(`OP_SUBTRACT_TO_ACC, 8'h05, 8'h05);
    sub(`OP_SUBTRACT_TO_ACC, 8'h03, 8'h05);
    sub(`OP_SUBTRACT_TO_ACC, 8'h80, 8'h01);
    sub(`OP_SUBTRACT_TO_ACC, 8'h10, 8'h01);
    sub(`OP_SUBTRACT_TO_MEM, 8'h05, 8'h05);
    sub(`OP_SUBTRACT_TO_MEM, 8'h03, 8'h05);
    sub(`OP_SUBTRACT_TO_MEM, 8'h7f, 8'hff);
    run(4'hf, 8'h00, 3'h0);
    apb(1'b0, `REG_STAT, 32'h0, {16'h0, cnt, 5'h0, 1'b1, last, 1'b0}, 1'b0);
    apb(1'b1, `REG_STAT, 32'h0000ff04, 32'h0, 1'b0);
    apb(1'b0, `REG_STAT, 32'h0, {30'h0, last, 1'b0}, 1'b0);
    apb(1'b0, `REG_ACC, 32'h0, {24'h0, ea}, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk(exec_ready, 1'b0);
    exec_valid <= 1'b1;
    exec_op <= `OP_COPY_SKIP_IF_ZERO;
    mem_rdata <= 8'h00;
    repeat (2) @(posedge clk_sys);
    exec_valid <= 1'b0;
    chk(acc, ea);
    chk(pc_skip, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h1, 32'h0, 1'b0);
    run(`OP_SKIP_IF_ZERO, 8'h00, 3'h0);
    test_done;
  end
endmodule // tb_skip_subtract_swap_exec
